// [rtl/ccm_defines.svh]
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

// cache control bit positions
`define CCM_CC_CMO_PF      9
`define CCM_CC_ECC_CHK     8
`define CCM_CC_CANCEL      7
`define CCM_CC_NL_PF       6
`define CCM_CC_DRAM_INJ    5
`define CCM_CC_TRAM_INJ    4
`define CCM_CC_ECC_EXCP    3
`define CCM_CC_ECC_EN      2
`define CCM_CC_SCPD        1
`define CCM_CC_EN          0
`define CCM_CC_RESET       32'h0000_0006
`define CCM_CC_WMASK       32'h0000_03ff

// misc feature control bit positions
`define CCM_MC_EXCL        17
`define CCM_MC_LDSPEC      12
`define CCM_MC_SIJUMP      11
`define CCM_MC_IMRET       10
`define CCM_MC_NMI_SEL     9
`define CCM_MC_BUSERR_INT  8
`define CCM_MC_ZC          7
`define CCM_MC_MISALGN     6
`define CCM_MC_BRANCH_PRED 3
`define CCM_MC_RESET       32'h0000_0008
`define CCM_MC_WMASK       32'h0002_1fc8

// csr addresses (arbitrary local selectors)
`define CCM_ADDR_CC        12'h7ca
`define CCM_ADDR_MC        12'h7d0

// cause and detail cause codes
`define CCM_NMI_CAUSE_RST  12'h001
`define CCM_NMI_CAUSE_TVEC 12'hfff
`define CCM_CAUSE_LOAD     12'h005
`define CCM_CAUSE_STORE    12'h007
`define CCM_CAUSE_LPAGE    12'h00d
`define CCM_CAUSE_SPAGE    12'h00f
`define CCM_CAUSE_BUS_INT  12'h012
`define CCM_DC_PMP         3'h1
`define CCM_DC_BUS         3'h2
`define CCM_DC_COPROC      3'h3
`define CCM_DC_SPMP        3'h6
`define CCM_DC_ECC         3'h7

// next-line page size, log2 of the page size in bytes
`define CCM_PAGE_BITS      12
// next-line step, log2 of the line size in bytes
`define CCM_LINE_BITS      6

`endif

// [rtl/ccm_pkg.sv]
package ccm_pkg;

  typedef enum logic [2:0]
  {
    CCM_ERR_BUS  = 3'h0,
    CCM_ERR_PMP  = 3'h1,
    CCM_ERR_ECC  = 3'h2,
    CCM_ERR_SPMP = 3'h3,
    CCM_ERR_COP  = 3'h4
  } ccm_err_e;

  typedef logic [31:0] ccm_word_t;

endpackage : ccm_pkg

// [rtl/ccm_ctrl.sv]
// Notes on behaviour
// - cache control bit 9 enables icache cmo prefetch, reset off
// - bit 8 enables icache ecc checking, reset 0, tied 0 if unconfigured
// - bit 7 enables cancel of first stage fetch on flow change
// - bit 6 prefetches next line on miss while bit 0 is set, unless crossing 4K
// - bits 5 and 4 inject ecc code into data and tag rams
// - bit 3 enables exception on double-bit icache ecc error
// - bit 2 enables icache ecc, reset enabled, tied 0 if unconfigured
// - scratchpad mode reuses data sram as fetch and load/store memory
// - scratchpad active only when bits one to zero equal 2'b10
// - bit 0 enables the icache, disabled after reset
// - misc bit 17 lets lr/sc drive exclusive flag on bus
// - misc bit 12 permits speculative loads to memory interface
// - misc bits 11 and 10 enable two trace modes
// - misc bit 9 selects nmi vector and cause 0x1 or 0xfff
// - misc bit 8 reports bus errors as exception or interrupt
// - bit 7 read-only 1 with zc only; with d, set only when fpu off, cleared any time
// - bit 6 permits misaligned i/f/d access; atomics always fault
// - bit 3 enables branch predictor, reset on; off predicts taken
// - plain bus error: cause 5 read, 7 write, detail 2
// - pmp errors detail 1, ecc errors detail 7
// - spmp errors cause 13 read, 15 write, detail 6
// - coprocessor write-back bus error: cause 5, detail 3
// - bus errors as interrupts use identifier 18
`timescale 1ns/1ps
`include "ccm_defines.svh"

module ccm_ctrl
  import ccm_pkg::*;
#(
  parameter bit HAS_ICACHE = 1'b1,
  parameter bit HAS_ECC    = 1'b1,
  parameter bit HAS_ZC     = 1'b1,
  parameter bit HAS_D      = 1'b1,
  parameter int PC_W       = 32
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // csr access
  input  wire logic              csr_we,
  input  wire logic [11:0]       csr_addr,
  input  wire logic [31:0]       csr_wdata,
  output      logic [31:0]       csr_rdata,
  // core context
  input  wire logic              fpu_off,
  input  wire logic [PC_W-1:0]   reset_pc,
  input  wire logic [PC_W-1:0]   trap_vec,
  // icache miss, next-line request
  input  wire logic              ic_miss,
  input  wire logic [PC_W-1:0]   ic_miss_addr,
  output      logic              ic_nl_req,
  output      logic [PC_W-1:0]   ic_nl_addr,
  // bus error report
  input  wire logic              berr_valid,
  input  wire logic              berr_write,
  input  wire logic [2:0]        berr_kind,
  output      logic              berr_exc,
  output      logic              berr_irq,
  output      logic [11:0]       berr_cause,
  output      logic [2:0]        berr_dcause,
  // control outputs
  output      logic              icache_enable,
  output      logic              icache_scratchpad_mode,
  output      logic              icache_scratchpad_active,
  output      logic              icache_cmo_prefetch_enable,
  output      logic              icache_ecc_check_enable,
  output      logic              icache_flow_cancel_enable,
  output      logic              icache_data_ram_ecc_inject,
  output      logic              icache_tag_ram_ecc_inject,
  output      logic              icache_ecc_exception_enable,
  output      logic              icache_ecc_enable,
  output      logic              exclusive_flag_enable,
  output      logic              speculative_load_enable,
  output      logic              trace_single_jump_mode,
  output      logic              trace_immediate_return_mode,
  output      logic              misaligned_access_enable,
  output      logic              branch_predictor_enable,
  output      logic              compressed_table_push_enable,
  output      logic [PC_W-1:0]   nmi_vector,
  output      logic [11:0]       nmi_cause
);

  if (PC_W <= `CCM_PAGE_BITS || PC_W > 64)
  begin : g_bad_pc_w
    $error("ccm_ctrl: PC_W out of range");
  end

  // --------------------------------------------------------------
  // writable masks from configuration
  // --------------------------------------------------------------
  localparam bit IC_ECC = HAS_ICACHE && HAS_ECC;
  localparam bit ZC_RO  = HAS_ZC && !HAS_D;
  localparam logic [31:0] CC_TIE =
    (IC_ECC ? 32'h0 : ((32'h1 << `CCM_CC_ECC_CHK) |
     (32'h1 << `CCM_CC_DRAM_INJ) | (32'h1 << `CCM_CC_TRAM_INJ) |
     (32'h1 << `CCM_CC_ECC_EXCP) | (32'h1 << `CCM_CC_ECC_EN))) |
    (HAS_ICACHE ? 32'h0 : ((32'h1 << `CCM_CC_CANCEL) |
     (32'h1 << `CCM_CC_NL_PF)));
  localparam logic [31:0] CC_MASK = `CCM_CC_WMASK & ~CC_TIE;
  localparam logic [31:0] MC_FIX1 =
    ZC_RO ? (32'h1 << `CCM_MC_ZC) : 32'h0;
  localparam logic [31:0] MC_MASK = HAS_ZC ? `CCM_MC_WMASK
    : (`CCM_MC_WMASK & ~(32'h1 << `CCM_MC_ZC));
  localparam logic [31:0] CC_RST  = `CCM_CC_RESET & CC_MASK;
  localparam logic [31:0] MC_RST  = `CCM_MC_RESET | MC_FIX1;

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [31:0]     cc_q, cc_d, mc_q, mc_d;
  logic [31:0]     rdata_d;
  logic            nl_req_d, exc_d, irq_d;
  logic [PC_W-1:0] nl_addr_d, nmi_vec_d;
  logic [11:0]     cause_d, nmi_cause_d;
  logic [2:0]      dcause_d;
  logic [PC_W-1:0] next_line;
  logic            mc_hit, zc_ok;

  always_comb
  begin
    cc_d   = cc_q;
    mc_d   = mc_q;
    mc_hit = csr_we && (csr_addr == `CCM_ADDR_MC);
    // zc enable only takes a write of 1 when fpu is off
    zc_ok  = fpu_off || !csr_wdata[`CCM_MC_ZC];
    if (csr_we && csr_addr == `CCM_ADDR_CC)
      cc_d = csr_wdata & CC_MASK;
    if (mc_hit)
    begin
      mc_d = (csr_wdata & MC_MASK) | MC_FIX1;
      if (ZC_RO)
        mc_d[`CCM_MC_ZC] = 1'b1;
      else if (HAS_ZC && !zc_ok)
        mc_d[`CCM_MC_ZC] = mc_q[`CCM_MC_ZC];
    end
    case (csr_addr)
      `CCM_ADDR_CC: rdata_d = cc_d;
      `CCM_ADDR_MC: rdata_d = mc_d;
      default:      rdata_d = 32'h0;
    endcase
  end

  // --------------------------------------------------------------
  // next-line prefetch, stays within a 4K page
  // --------------------------------------------------------------
  always_comb
  begin
    next_line = ic_miss_addr + (PC_W'(1) << `CCM_LINE_BITS);
    nl_req_d  = ic_miss && cc_q[`CCM_CC_NL_PF] && cc_q[`CCM_CC_EN] &&
      (next_line[PC_W-1:`CCM_PAGE_BITS] ==
       ic_miss_addr[PC_W-1:`CCM_PAGE_BITS]);
    nl_addr_d = next_line;
    nmi_vec_d   = mc_q[`CCM_MC_NMI_SEL] ? trap_vec : reset_pc;
    nmi_cause_d = mc_q[`CCM_MC_NMI_SEL] ? `CCM_NMI_CAUSE_TVEC
                                        : `CCM_NMI_CAUSE_RST;
  end

  // --------------------------------------------------------------
  // bus error cause encoding
  // --------------------------------------------------------------
  always_comb
  begin
    cause_d  = berr_write ? `CCM_CAUSE_STORE : `CCM_CAUSE_LOAD;
    dcause_d = `CCM_DC_BUS;
    case (ccm_err_e'(berr_kind))
      CCM_ERR_BUS:  dcause_d = `CCM_DC_BUS;
      CCM_ERR_PMP:  dcause_d = `CCM_DC_PMP;
      CCM_ERR_ECC:  dcause_d = `CCM_DC_ECC;
      CCM_ERR_SPMP:
      begin
        cause_d  = berr_write ? `CCM_CAUSE_SPAGE
                              : `CCM_CAUSE_LPAGE;
        dcause_d = `CCM_DC_SPMP;
      end
      CCM_ERR_COP:
      begin
        cause_d  = `CCM_CAUSE_LOAD;
        dcause_d = `CCM_DC_COPROC;
      end
      default:      dcause_d = `CCM_DC_BUS;
    endcase
    if (mc_q[`CCM_MC_BUSERR_INT])
      cause_d = `CCM_CAUSE_BUS_INT;
    exc_d = berr_valid && !mc_q[`CCM_MC_BUSERR_INT];
    irq_d = berr_valid && mc_q[`CCM_MC_BUSERR_INT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cc_q        <= CC_RST;
      mc_q        <= MC_RST;
      csr_rdata   <= 32'h0;
      ic_nl_req   <= 1'b0;
      ic_nl_addr  <= '0;
      berr_exc    <= 1'b0;
      berr_irq    <= 1'b0;
      berr_cause  <= 12'h0;
      berr_dcause <= 3'h0;
      nmi_vector  <= '0;
      nmi_cause   <= `CCM_NMI_CAUSE_RST;
    end
    else
    begin
      cc_q        <= cc_d;
      mc_q        <= mc_d;
      csr_rdata   <= rdata_d;
      ic_nl_req   <= nl_req_d;
      ic_nl_addr  <= nl_addr_d;
      berr_exc    <= exc_d;
      berr_irq    <= irq_d;
      berr_cause  <= cause_d;
      berr_dcause <= dcause_d;
      nmi_vector  <= nmi_vec_d;
      nmi_cause   <= nmi_cause_d;
    end
  end

  // --------------------------------------------------------------
  // field outputs, registered copies of the state
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      icache_enable                <= 1'b0;
      icache_scratchpad_mode       <= CC_RST[`CCM_CC_SCPD];
      icache_scratchpad_active     <= CC_RST[`CCM_CC_SCPD] &&
                                      !CC_RST[`CCM_CC_EN];
      icache_cmo_prefetch_enable   <= 1'b0;
      icache_ecc_check_enable      <= 1'b0;
      icache_flow_cancel_enable    <= 1'b0;
      icache_data_ram_ecc_inject   <= 1'b0;
      icache_tag_ram_ecc_inject    <= 1'b0;
      icache_ecc_exception_enable  <= 1'b0;
      icache_ecc_enable            <= CC_RST[`CCM_CC_ECC_EN];
      exclusive_flag_enable        <= 1'b0;
      speculative_load_enable      <= 1'b0;
      trace_single_jump_mode       <= 1'b0;
      trace_immediate_return_mode  <= 1'b0;
      misaligned_access_enable     <= 1'b0;
      branch_predictor_enable      <= MC_RST[`CCM_MC_BRANCH_PRED];
      compressed_table_push_enable <= MC_RST[`CCM_MC_ZC];
    end
    else
    begin
      icache_enable                <= cc_d[`CCM_CC_EN];
      icache_scratchpad_mode       <= cc_d[`CCM_CC_SCPD];
      icache_scratchpad_active     <= cc_d[`CCM_CC_SCPD] &&
                                      !cc_d[`CCM_CC_EN];
      icache_cmo_prefetch_enable   <= cc_d[`CCM_CC_CMO_PF];
      icache_ecc_check_enable      <= cc_d[`CCM_CC_ECC_CHK];
      icache_flow_cancel_enable    <= cc_d[`CCM_CC_CANCEL];
      icache_data_ram_ecc_inject   <= cc_d[`CCM_CC_DRAM_INJ];
      icache_tag_ram_ecc_inject    <= cc_d[`CCM_CC_TRAM_INJ];
      icache_ecc_exception_enable  <= cc_d[`CCM_CC_ECC_EXCP];
      icache_ecc_enable            <= cc_d[`CCM_CC_ECC_EN];
      exclusive_flag_enable        <= mc_d[`CCM_MC_EXCL];
      speculative_load_enable      <= mc_d[`CCM_MC_LDSPEC];
      trace_single_jump_mode       <= mc_d[`CCM_MC_SIJUMP];
      trace_immediate_return_mode  <= mc_d[`CCM_MC_IMRET];
      // atomics fault on misalignment in the lsu regardless
      misaligned_access_enable     <= mc_d[`CCM_MC_MISALGN];
      branch_predictor_enable      <= mc_d[`CCM_MC_BRANCH_PRED];
      compressed_table_push_enable <= mc_d[`CCM_MC_ZC];
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_scpd_active: assert property (@(posedge clk) disable iff (rst)
    icache_scratchpad_active ==
      (cc_q[`CCM_CC_SCPD] && !cc_q[`CCM_CC_EN]))
    else $error("scratchpad active mismatch");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    ((cc_q & ~`CCM_CC_WMASK) == 32'h0) && ((mc_q & ~`CCM_MC_WMASK) == 32'h0))
    else $error("reserved bit set");
  a_nmi_cause: assert property (@(posedge clk) disable iff (rst)
    ##1 nmi_cause == ($past(mc_q[`CCM_MC_NMI_SEL]) ? `CCM_NMI_CAUSE_TVEC
                                                   : `CCM_NMI_CAUSE_RST))
    else $error("nmi cause wrong");
  a_berr_route: assert property (@(posedge clk) disable iff (rst)
    berr_valid |=> (berr_exc != berr_irq))
    else $error("bus error not routed once");
  a_berr_int_id: assert property (@(posedge clk) disable iff (rst)
    berr_irq |-> berr_cause == `CCM_CAUSE_BUS_INT)
    else $error("bus error irq id wrong");
  a_spmp_code: assert property (@(posedge clk) disable iff (rst)
    berr_valid && berr_kind == CCM_ERR_SPMP && !mc_q[`CCM_MC_BUSERR_INT]
    |=> berr_dcause == `CCM_DC_SPMP &&
      berr_cause == ($past(berr_write) ? `CCM_CAUSE_SPAGE
                                       : `CCM_CAUSE_LPAGE))
    else $error("spmp code wrong");
  a_cop_code: assert property (@(posedge clk) disable iff (rst)
    berr_valid && berr_kind == CCM_ERR_COP && !mc_q[`CCM_MC_BUSERR_INT]
    |=> berr_cause == `CCM_CAUSE_LOAD && berr_dcause == `CCM_DC_COPROC)
    else $error("coprocessor code wrong");
  a_nl_page: assert property (@(posedge clk) disable iff (rst)
    ic_nl_req |-> ic_nl_addr[PC_W-1:`CCM_PAGE_BITS] ==
      $past(ic_miss_addr[PC_W-1:`CCM_PAGE_BITS]))
    else $error("next line crossed page");

endmodule : ccm_ctrl

// [verif/ccm_ctrl_tb.sv]
`timescale 1ns/1ps
`include "ccm_defines.svh"

module ccm_ctrl_tb
  import ccm_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clk;
  logic        rst;
  logic        csr_we;
  logic [11:0] csr_addr;
  ccm_word_t   csr_wdata;
  ccm_word_t   csr_rdata;
  logic        fpu_off;
  logic [31:0] reset_pc;
  logic [31:0] trap_vec;
  logic        ic_miss;
  logic [31:0] ic_miss_addr;
  logic        ic_nl_req;
  logic [31:0] ic_nl_addr;
  logic        berr_valid;
  logic        berr_write;
  logic [2:0]  berr_kind;
  logic        berr_exc;
  logic        berr_irq;
  logic [11:0] berr_cause;
  logic [2:0]  berr_dcause;
  logic [9:0]  ccf;
  logic [6:0]  mcf;
  logic        sp_act;
  logic [31:0] nmi_vector;
  logic [11:0] nmi_cause;
  int          fails;
  int          n_checks;

  always #20 clk = ~clk;

  ccm_ctrl dut
  (
    .clk                          (clk),
    .rst                          (rst),
    .csr_we                       (csr_we),
    .csr_addr                     (csr_addr),
    .csr_wdata                    (csr_wdata),
    .csr_rdata                    (csr_rdata),
    .fpu_off                      (fpu_off),
    .reset_pc                     (reset_pc),
    .trap_vec                     (trap_vec),
    .ic_miss                      (ic_miss),
    .ic_miss_addr                 (ic_miss_addr),
    .ic_nl_req                    (ic_nl_req),
    .ic_nl_addr                   (ic_nl_addr),
    .berr_valid                   (berr_valid),
    .berr_write                   (berr_write),
    .berr_kind                    (berr_kind),
    .berr_exc                     (berr_exc),
    .berr_irq                     (berr_irq),
    .berr_cause                   (berr_cause),
    .berr_dcause                  (berr_dcause),
    .icache_enable                (ccf[0]),
    .icache_scratchpad_mode       (ccf[1]),
    .icache_scratchpad_active     (sp_act),
    .icache_cmo_prefetch_enable   (ccf[9]),
    .icache_ecc_check_enable      (ccf[8]),
    .icache_flow_cancel_enable    (ccf[7]),
    .icache_data_ram_ecc_inject   (ccf[5]),
    .icache_tag_ram_ecc_inject    (ccf[4]),
    .icache_ecc_exception_enable  (ccf[3]),
    .icache_ecc_enable            (ccf[2]),
    .exclusive_flag_enable        (mcf[6]),
    .speculative_load_enable      (mcf[5]),
    .trace_single_jump_mode       (mcf[4]),
    .trace_immediate_return_mode  (mcf[3]),
    .misaligned_access_enable     (mcf[2]),
    .branch_predictor_enable      (mcf[1]),
    .compressed_table_push_enable (mcf[0]),
    .nmi_vector                   (nmi_vector),
    .nmi_cause                    (nmi_cause)
  );
  assign ccf[6] = ic_nl_req;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task chk(input ccm_word_t got, input ccm_word_t exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // inputs always move 1 ns after the rising edge
  task wr(input logic [11:0] a, input ccm_word_t d);
    csr_we    = 1'b1;
    csr_addr  = a;
    csr_wdata = d;
    @(posedge clk);
    #1;
    csr_we    = 1'b0;
    // idle edge so a following write never re-raises the strobe at once
    @(posedge clk);
    #1;
  endtask : wr

  task rd(input logic [11:0] a, input ccm_word_t e);
    csr_addr = a;
    @(posedge clk);
    #1;
    chk(csr_rdata, e);
  endtask : rd

  task berr(input logic w, input logic [2:0] k, input logic [11:0] c,
            input logic [2:0] dc, input logic irq);
    berr_valid = 1'b1;
    berr_write = w;
    berr_kind  = k;
    @(posedge clk);
    #1;
    berr_valid = 1'b0;
    chk(32'(berr_exc), 32'(!irq));
    chk(32'(berr_irq), 32'(irq));
    chk(32'(berr_cause), 32'(c));
    chk(32'(berr_dcause), 32'(dc));
    @(posedge clk);
    #1;
  endtask : berr

  task miss(input logic [31:0] a, input logic req, input logic [31:0] na);
    ic_miss      = 1'b1;
    ic_miss_addr = a;
    @(posedge clk);
    #1;
    ic_miss      = 1'b0;
    chk(32'(ic_nl_req), 32'(req));
    if (req)
      chk(ic_nl_addr, na);
    @(posedge clk);
    #1;
  endtask : miss

  function automatic logic [2:0] dcf(input int k);
    case (k)
      0: return 3'h2;
      1: return 3'h1;
      2: return 3'h7;
      3: return 3'h6;
      default: return 3'h3;
    endcase
  endfunction : dcf

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0; rst = 1'b1; csr_we = 1'b0; csr_addr = 12'h000;
    csr_wdata = 32'h0; fpu_off = 1'b0; reset_pc = 32'h0000_0100;
    trap_vec = 32'h0000_2000; ic_miss = 1'b0; ic_miss_addr = 32'h0;
    berr_valid = 1'b0; berr_write = 1'b0; berr_kind = 3'h0;
    fails = 0; n_checks = 0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(`CCM_ADDR_CC, 32'h0000_0006);
    chk(32'(ccf & 10'h3bf), 32'h006);
    chk(32'(sp_act), 32'h1);
    rd(`CCM_ADDR_MC, 32'h0000_0008);
    chk(32'(mcf), 32'h02);
    chk(32'(nmi_cause), 32'h001);
    chk(nmi_vector, reset_pc);
    // walking one over the cache control fields
    for (int i = 0; i < 10; i++)
    begin
      wr(`CCM_ADDR_CC, 32'h1 << i);
      if (i != 6)
        chk(32'(ccf & 10'h3bf), 32'((10'h1 << i) & 10'h3bf));
      chk(32'(sp_act), 32'(i == 1));
    end
    wr(`CCM_ADDR_CC, 32'hffff_ffff);
    chk(32'(sp_act), 32'h0);
    rd(`CCM_ADDR_CC, 32'h0000_03ff);
    // bit 7 write of 1 is dropped while the fpu is on
    wr(`CCM_ADDR_MC, 32'hffff_ffff);
    rd(`CCM_ADDR_MC, 32'h0002_1f48);
    chk(32'(mcf), 32'h7e);
    fpu_off = 1'b1;
    wr(`CCM_ADDR_MC, 32'hffff_ffff);
    @(posedge clk);
    #1;
    chk(32'(mcf), 32'h7f);
    chk(nmi_vector, trap_vec);
    chk(32'(nmi_cause), 32'h0fff);
    fpu_off = 1'b0;
    wr(`CCM_ADDR_MC, 32'h0000_0080);
    rd(`CCM_ADDR_MC, 32'h0000_0080);
    wr(`CCM_ADDR_MC, 32'h0000_0000);
    wr(`CCM_ADDR_MC, 32'h0000_0080);
    rd(`CCM_ADDR_MC, 32'h0000_0000);
    chk(32'(mcf), 32'h00);
    chk(nmi_vector, reset_pc);
    chk(32'(nmi_cause), 32'h001);
    // bus errors as exceptions, then as interrupts
    for (int k = 0; k < 5; k++)
      for (int w = 0; w < 2; w++)
        if (!(k == 4 && w == 1))
          berr(w[0], k[2:0], (k == 3) ? (w ? 12'h00f : 12'h00d) :
               ((w == 1) ? 12'h007 : 12'h005), dcf(k), 1'b0);
    @(posedge clk);
    #1;
    chk(32'(berr_exc), 32'h0);
    wr(`CCM_ADDR_MC, 32'h0000_0100);
    for (int k = 0; k < 5; k++)
      for (int w = 0; w < 2; w++)
        berr(w[0], k[2:0], 12'h012, dcf(k), 1'b1);
    // next-line prefetch and the 4K boundary
    wr(`CCM_ADDR_CC, 32'h0000_0041);
    miss(32'h0000_1000, 1'b1, 32'h0000_1040);
    miss(32'h0000_1fc0, 1'b0, 32'h0);
    wr(`CCM_ADDR_CC, 32'h0000_0001);
    miss(32'h0000_1000, 1'b0, 32'h0);
    rd(12'h000, 32'h0);
    // second reset in mid-run
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    rd(`CCM_ADDR_CC, 32'h0000_0006);
    rd(`CCM_ADDR_MC, 32'h0000_0008);
    conclude;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude;
  end

endmodule : ccm_ctrl_tb
